// ===== hw/iosm_pkg.sv
// Package: constants and carriers for the I/O signal allocation matrix
package iosm_pkg;

   // ****************************************************************
   // Register map (byte addresses on the APB slave)
   // ****************************************************************
   localparam logic [7:0] IOSM_OFS_IN_A = 8'h00;
   localparam logic [7:0] IOSM_OFS_IN_B = 8'h04;
   localparam logic [7:0] IOSM_OFS_IN_C = 8'h08;
   localparam logic [7:0] IOSM_OFS_IN_D = 8'h0C;
   localparam logic [7:0] IOSM_OFS_OUT_A = 8'h10;
   localparam logic [7:0] IOSM_OFS_OUT_B = 8'h14;
   localparam logic [7:0] IOSM_OFS_OUT_C = 8'h18;
   localparam logic [7:0] IOSM_OFS_OUT_D = 8'h1C;
   localparam logic [7:0] IOSM_OFS_POL = 8'h20;
   localparam logic [7:0] IOSM_OFS_STATUS = 8'h24;

   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [15:0] IOSM_RST_IN_A = 16'h8888;
   localparam logic [15:0] IOSM_RST_IN_B = 16'h8888;
   localparam logic [15:0] IOSM_RST_IN_C = 16'h8888;
   localparam logic [15:0] IOSM_RST_IN_D = 16'h8888;
   localparam logic [15:0] IOSM_RST_OUT_A = 16'h0000;
   localparam logic [15:0] IOSM_RST_OUT_B = 16'h0100;
   localparam logic [15:0] IOSM_RST_OUT_C = 16'h0000;
   localparam logic [15:0] IOSM_RST_OUT_D = 16'h0000;
   localparam logic [15:0] IOSM_RST_POL = 16'h0000;

   // ****************************************************************
   // Selector codes and field positions
   // ****************************************************************
   localparam logic [3:0] IOSM_CODE_ON = 4'h7;
   localparam logic [3:0] IOSM_CODE_OFF = 4'h8;
   localparam logic [3:0] IOSM_CODE_INV_BASE = 4'hA;
   localparam logic [3:0] IOSM_CODE_PIN_FIRST = 4'h1;
   localparam logic [3:0] IOSM_CODE_PIN_LAST = 4'h6;
   localparam logic [3:0] IOSM_CODE_PROBE_MIN = 4'h4;
   localparam logic [3:0] IOSM_CODE_INV_TOP = 4'hF;
   localparam logic [3:0] IOSM_POL_INVERT = 4'h1;
   localparam int IOSM_NUM_PINS = 6;
   localparam int IOSM_NUM_PAIRS = 3;
   localparam int IOSM_NUM_OUT = 10;
   localparam int IOSM_DIGIT_0 = 0;
   localparam int IOSM_DIGIT_1 = 4;
   localparam int IOSM_DIGIT_2 = 8;
   localparam int IOSM_DIGIT_3 = 12;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic forced_stop_in;
      logic home_switch_in;
      logic probe2_latch_in;
      logic probe1_latch_in;
      logic reverse_torque_limit_in;
      logic forward_torque_limit_in;
      logic reverse_drive_prohibit;
      logic forward_drive_prohibit;
   } iosm_in_func_s;

   // Bit order matches the selector order used inside the matrix
   typedef struct packed {
      logic maintenance_out;
      logic near_position_out;
      logic warning_out;
      logic brake_out;
      logic speed_limit_active_out;
      logic torque_limit_active_out;
      logic servo_ready_out;
      logic rotation_detect_out;
      logic speed_match_out;
      logic positioning_done_out;
   } iosm_out_func_s;

endpackage

// ===== hw/iosm_matrix.sv
// Module: I/O signal allocation matrix with APB parameter registers
//
// What this block does
// - Functions sharing one input pin all follow that same pin level.
// - Input selector codes 1-6 pick pins 1-6 normal, A-F the same inverted.
// - Normal code: slash functions active on closed, others on open.
// - Inverted code: slash functions active on open, others on closed.
// - Code 7 holds a function active, or inactive if edge-evaluated.
// - Code 8 holds a function inactive.
// - Probe latch inputs may use only pins 4 to 6.
// - Forward prohibit in in_a digit 3; reverse, fwd/rev torque in in_b 0,2,3.
// - An output function not evaluated in this mode is taken as OFF.
// - Several functions on one output pair are ORed.
// - Output code 1-3 picks pair 1-3, code 0 disables.
// - Output selectors reset to 0, the brake selector to 1.
// - Output selector digits sit in out_a, out_b, out_c and out_d.
// - Polarity digits 0-2 invert pairs 1-3 when 1, default none.
`timescale 1ns/1ps
module iosm_matrix
   import iosm_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] contact_closed,
   input wire iosm_out_func_s out_func_req,
   input wire iosm_out_func_s out_func_valid,
   output iosm_in_func_s in_func_active,
   output logic [2:0] pair_closed
);

   // ****************************************************************
   // Input synchroniser
   // ****************************************************************
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;

   // Two stages; only sync2 is read by the matrix
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
      end else begin
         sync1_reg <= contact_closed;
         sync2_reg <= sync1_reg;
      end
   end

   // ****************************************************************
   // Parameter registers and APB slave
   // ****************************************************************
   logic [15:0] in_a_reg, in_b_reg, in_c_reg, in_d_reg;
   logic [15:0] out_a_reg, out_b_reg, out_c_reg, out_d_reg, pol_reg;
   logic [15:0] in_a_next, in_b_next, in_c_next, in_d_next;
   logic [15:0] out_a_next, out_b_next, out_c_next, out_d_next, pol_next;
   logic [31:0] prdata_next;
   logic pready_next, pslverr_next;
   logic [31:0] status_word;
   logic access_done;
   logic addr_hit;

   assign access_done = psel & penable & pready;

   // Decode, read mux and write; one wait state keeps prdata registered
   always_comb begin
      in_a_next = in_a_reg;
      in_b_next = in_b_reg;
      in_c_next = in_c_reg;
      in_d_next = in_d_reg;
      out_a_next = out_a_reg;
      out_b_next = out_b_reg;
      out_c_next = out_c_reg;
      out_d_next = out_d_reg;
      pol_next = pol_reg;
      prdata_next = prdata;
      addr_hit = 1'b1;
      unique case (paddr)
         IOSM_OFS_IN_A: prdata_next = {16'h0000, in_a_reg};
         IOSM_OFS_IN_B: prdata_next = {16'h0000, in_b_reg};
         IOSM_OFS_IN_C: prdata_next = {16'h0000, in_c_reg};
         IOSM_OFS_IN_D: prdata_next = {16'h0000, in_d_reg};
         IOSM_OFS_OUT_A: prdata_next = {16'h0000, out_a_reg};
         IOSM_OFS_OUT_B: prdata_next = {16'h0000, out_b_reg};
         IOSM_OFS_OUT_C: prdata_next = {16'h0000, out_c_reg};
         IOSM_OFS_OUT_D: prdata_next = {16'h0000, out_d_reg};
         IOSM_OFS_POL: prdata_next = {16'h0000, pol_reg};
         IOSM_OFS_STATUS: prdata_next = status_word;
         default: begin
            prdata_next = 32'h0000_0000;
            addr_hit = 1'b0;
         end
      endcase
      if (pwrite) begin
         prdata_next = 32'h0000_0000;
      end
      pready_next = psel & penable & ~pready;
      pslverr_next = psel & penable & ~pready & ~addr_hit;
      if (access_done && pwrite) begin
         unique case (paddr)
            IOSM_OFS_IN_A: in_a_next = pwdata[15:0];
            IOSM_OFS_IN_B: in_b_next = pwdata[15:0];
            IOSM_OFS_IN_C: in_c_next = pwdata[15:0];
            IOSM_OFS_IN_D: in_d_next = pwdata[15:0];
            IOSM_OFS_OUT_A: out_a_next = pwdata[15:0];
            IOSM_OFS_OUT_B: out_b_next = pwdata[15:0];
            IOSM_OFS_OUT_C: out_c_next = pwdata[15:0];
            IOSM_OFS_OUT_D: out_d_next = pwdata[15:0];
            IOSM_OFS_POL: pol_next = pwdata[15:0];
            default: pol_next = pol_reg;
         endcase
      end
   end

   // Register stage for the parameter file and bus answer
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_a_reg <= IOSM_RST_IN_A;
         in_b_reg <= IOSM_RST_IN_B;
         in_c_reg <= IOSM_RST_IN_C;
         in_d_reg <= IOSM_RST_IN_D;
         out_a_reg <= IOSM_RST_OUT_A;
         out_b_reg <= IOSM_RST_OUT_B;
         out_c_reg <= IOSM_RST_OUT_C;
         out_d_reg <= IOSM_RST_OUT_D;
         pol_reg <= IOSM_RST_POL;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         in_a_reg <= in_a_next;
         in_b_reg <= in_b_next;
         in_c_reg <= in_c_next;
         in_d_reg <= in_d_next;
         out_a_reg <= out_a_next;
         out_b_reg <= out_b_next;
         out_c_reg <= out_c_next;
         out_d_reg <= out_d_next;
         pol_reg <= pol_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
      end
   end

   // ****************************************************************
   // Input side decode
   // ****************************************************************
   // One decoder per function: every function reading the same pin sees
   // the same synchronised level, so sharing a pin needs no extra gate.
   function automatic logic in_decode(input logic [3:0] code,
                                      input logic [5:0] pins,
                                      input logic slash,
                                      input logic edge_fn,
                                      input logic probe);
      logic contact;
      logic act;
      contact = 1'b0;
      act = 1'b0;
      if (code >= IOSM_CODE_PIN_FIRST && code <= IOSM_CODE_PIN_LAST) begin
         contact = pins[3'(code - IOSM_CODE_PIN_FIRST)];
         act = slash ? contact : ~contact;
         if (probe && code < IOSM_CODE_PROBE_MIN) begin
            act = 1'b0;
         end
      end else if (code >= IOSM_CODE_INV_BASE) begin
         contact = pins[3'(code - IOSM_CODE_INV_BASE)];
         act = slash ? ~contact : contact;
         if (probe && code < IOSM_CODE_INV_BASE + 4'h3) begin
            act = 1'b0;
         end
      end else if (code == IOSM_CODE_ON) begin
         act = ~edge_fn;
      end else begin
         act = 1'b0;
      end
      return act;
   endfunction

   iosm_in_func_s in_func_next;

   // Field positions of each input selector
   always_comb begin
      in_func_next.forward_drive_prohibit = in_decode(
         in_a_reg[IOSM_DIGIT_3 +: 4], sync2_reg, 1'b0, 1'b0, 1'b0);
      in_func_next.reverse_drive_prohibit = in_decode(
         in_b_reg[IOSM_DIGIT_0 +: 4], sync2_reg, 1'b0, 1'b0, 1'b0);
      in_func_next.forward_torque_limit_in = in_decode(
         in_b_reg[IOSM_DIGIT_2 +: 4], sync2_reg, 1'b1, 1'b0, 1'b0);
      in_func_next.reverse_torque_limit_in = in_decode(
         in_b_reg[IOSM_DIGIT_3 +: 4], sync2_reg, 1'b1, 1'b0, 1'b0);
      in_func_next.home_switch_in = in_decode(
         in_c_reg[IOSM_DIGIT_0 +: 4], sync2_reg, 1'b1, 1'b0, 1'b0);
      in_func_next.probe1_latch_in = in_decode(
         in_c_reg[IOSM_DIGIT_1 +: 4], sync2_reg, 1'b1, 1'b1, 1'b1);
      in_func_next.probe2_latch_in = in_decode(
         in_c_reg[IOSM_DIGIT_2 +: 4], sync2_reg, 1'b1, 1'b1, 1'b1);
      in_func_next.forced_stop_in = in_decode(
         in_d_reg[IOSM_DIGIT_0 +: 4], sync2_reg, 1'b0, 1'b0, 1'b0);
   end

   // ****************************************************************
   // Output side merge
   // ****************************************************************
   logic [3:0] out_sel [IOSM_NUM_OUT];
   logic [2:0] pair_next;
   logic [IOSM_NUM_OUT-1:0] out_eff;

   // Selector digit of each output function
   assign out_sel[0] = out_a_reg[IOSM_DIGIT_0 +: 4];
   assign out_sel[1] = out_a_reg[IOSM_DIGIT_1 +: 4];
   assign out_sel[2] = out_a_reg[IOSM_DIGIT_2 +: 4];
   assign out_sel[3] = out_a_reg[IOSM_DIGIT_3 +: 4];
   assign out_sel[4] = out_b_reg[IOSM_DIGIT_0 +: 4];
   assign out_sel[5] = out_b_reg[IOSM_DIGIT_1 +: 4];
   assign out_sel[6] = out_b_reg[IOSM_DIGIT_2 +: 4];
   assign out_sel[7] = out_b_reg[IOSM_DIGIT_3 +: 4];
   assign out_sel[8] = out_c_reg[IOSM_DIGIT_0 +: 4];
   assign out_sel[9] = out_d_reg[IOSM_DIGIT_2 +: 4];

   // Undetected functions count as OFF before they are merged
   assign out_eff = out_func_req & out_func_valid;

   // OR every function routed to a pair, then apply the pair polarity;
   // codes above 3 route nowhere, same as disabled
   always_comb begin
      pair_next = 3'b000;
      for (int f = 0; f < IOSM_NUM_OUT; f++) begin
         for (int p = 0; p < IOSM_NUM_PAIRS; p++) begin
            if (out_sel[f] == 4'(p + 1)) begin
               pair_next[p] = pair_next[p] | out_eff[f];
            end
         end
      end
      for (int p = 0; p < IOSM_NUM_PAIRS; p++) begin
         if (pol_reg[4*p +: 4] == IOSM_POL_INVERT) begin
            pair_next[p] = ~pair_next[p];
         end
      end
   end

   // Registered outputs so pins never glitch on selector changes
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         in_func_active <= '0;
         pair_closed <= 3'b000;
      end else begin
         in_func_active <= in_func_next;
         pair_closed <= pair_next;
      end
   end

   assign status_word = {15'h0000, pair_closed, in_func_active, sync2_reg};

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence home_code_s(logic [3:0] c);
      in_c_reg[IOSM_DIGIT_0 +: 4] == c;
   endsequence

   home_off_a: assert property (home_code_s(IOSM_CODE_OFF) |=>
      !in_func_active.home_switch_in) else $error("home not inactive");
   home_supply_a: assert property (home_code_s(4'h9) |=>
      !in_func_active.home_switch_in) else $error("code 9 not inactive");
   stop_forced_a: assert property (
      in_d_reg[IOSM_DIGIT_0 +: 4] == IOSM_CODE_ON |=>
      in_func_active.forced_stop_in) else $error("code 7 not active");
   probe_hold_a: assert property (
      in_c_reg[IOSM_DIGIT_1 +: 4] == IOSM_CODE_ON |=>
      !in_func_active.probe1_latch_in) else $error("probe code 7 active");
   probe_pin_a: assert property (
      in_c_reg[IOSM_DIGIT_2 +: 4] == 4'h2 |=>
      !in_func_active.probe2_latch_in) else $error("probe on low pin");
   stop_normal_a: assert property (
      in_d_reg[IOSM_DIGIT_0 +: 4] == 4'h1 |=>
      in_func_active.forced_stop_in == !$past(sync2_reg[0]))
      else $error("normal sense wrong");
   torque_inv_a: assert property (
      in_b_reg[IOSM_DIGIT_2 +: 4] == 4'hE |=>
      in_func_active.forward_torque_limit_in == !$past(sync2_reg[4]))
      else $error("inverted sense wrong");
   pin_sync_a: assert property (
      (in_c_reg[IOSM_DIGIT_0 +: 4] == 4'h3 && $stable(in_c_reg)) [*3] |->
      in_func_active.home_switch_in == $past(contact_closed[2], 3))
      else $error("sync depth wrong");
   brake_reset_a: assert property ($past(sys_rst) |->
      out_b_reg == IOSM_RST_OUT_B && out_a_reg == 16'h0000)
      else $error("output selector reset wrong");
   pair_or_a: assert property (
      out_sel[6] == 4'h2 && out_eff[6] && pol_reg == 16'h0000 |=>
      pair_closed[1]) else $error("pair or missing");
   skip_invalid_a: assert property (
      out_a_reg == 16'h0003 && out_b_reg == 16'h0000 &&
      out_c_reg == 16'h0000 && out_d_reg == 16'h0000 &&
      pol_reg == 16'h0000 && !out_func_valid.positioning_done_out |=>
      !pair_closed[2]) else $error("undetected function drove pair");
   pol_invert_a: assert property (
      out_a_reg == 16'h0000 && out_b_reg == 16'h0000 &&
      out_c_reg == 16'h0000 && out_d_reg == 16'h0000 &&
      pol_reg == 16'h0001 |=> pair_closed == 3'b001)
      else $error("polarity not applied");

endmodule // iosm_matrix

// ===== tb/iosm_io_partner.sv
// Far-side model: connector contact switches and output circuit loads
`timescale 1ns/1ps
module iosm_io_partner (
   input wire logic core_clk,
   input wire logic [5:0] contact_want,
   input wire logic [2:0] pair_closed,
   output logic [5:0] contact_closed,
   output logic [2:0] load_on
);
   // ****************************************************************
   // Contacts and loads
   // ****************************************************************
   logic [5:0] held;
   initial begin
      held = 6'h00;
      contact_closed = 6'h00;
   end
   // Contacts bounce inside the cycle before settling, never clean
   always @(posedge core_clk) begin
      if (contact_want !== held) begin
         held <= contact_want;
         contact_closed <= #23 ~contact_want;
         contact_closed <= #61 contact_want;
      end
   end
   // A load is energised while its pair is closed
   assign load_on = pair_closed;
endmodule // iosm_io_partner

// ===== tb/tb_top.sv
// Self-checking bench for the I/O signal allocation matrix
`timescale 1ns/1ps
module tb_top
   import iosm_pkg::*;
;
   // ****************************************************************
   // Signals, models and bus tasks
   // ****************************************************************
   logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] contact_closed, contact_want;
   logic [2:0] pair_closed, load_on;
   iosm_out_func_s out_func_req, out_func_valid;
   iosm_in_func_s in_func_active;
   int miscompares, n_tests;
   logic [15:0] in_cfg [4];
   logic [15:0] out_cfg [4];
   logic [15:0] pol_cfg;
   localparam int IN_REG [8] = '{0, 1, 1, 1, 2, 2, 2, 3};
   localparam int IN_DIG [8] = '{3, 0, 2, 3, 1, 2, 0, 0};
   localparam int OUT_REG [10] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 3};
   localparam int OUT_DIG [10] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 2};
   localparam logic [7:0] SLASH_FN = 8'h7C;
   localparam logic [7:0] EDGE_FN = 8'h30;
   localparam logic [3:0] PROBE_OK [10] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
      4'h0, 4'h9, 4'hD, 4'hE, 4'hF};
   localparam logic [15:0] RST_VAL [9] = '{IOSM_RST_IN_A, IOSM_RST_IN_B,
      IOSM_RST_IN_C, IOSM_RST_IN_D, IOSM_RST_OUT_A, IOSM_RST_OUT_B,
      IOSM_RST_OUT_C, IOSM_RST_OUT_D, IOSM_RST_POL};

   // Free-running 10 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   iosm_matrix i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .contact_closed(contact_closed),
      .out_func_req(out_func_req), .out_func_valid(out_func_valid),
      .in_func_active(in_func_active), .pair_closed(pair_closed));

   iosm_io_partner i_far (.core_clk(core_clk),
      .contact_want(contact_want), .pair_closed(pair_closed),
      .contact_closed(contact_closed), .load_on(load_on));

   // Expected input function states for a given set of contacts
   function automatic logic [7:0] exp_in(input logic [5:0] cl);
      logic [3:0] c;
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         c = in_cfg[IN_REG[i]][IN_DIG[i]*4 +: 4];
         if (c >= 4'h1 && c <= 4'h6 && !(EDGE_FN[i] && c < 4'h4))
            r[i] = SLASH_FN[i] ~^ cl[c - 4'h1];
         else if (c >= 4'hA && !(EDGE_FN[i] && c < 4'hD))
            r[i] = SLASH_FN[i] ^ cl[c - 4'hA];
         else if (c == 4'h7)
            r[i] = !EDGE_FN[i];
      end
      return r;
   endfunction

   // Expected pair states; codes 4 and up route nowhere
   function automatic logic [2:0] exp_out(input logic [9:0] on);
      logic [3:0] c;
      logic [2:0] r;
      r = 3'h0;
      for (int j = 0; j < 10; j++) begin
         c = out_cfg[OUT_REG[j]][OUT_DIG[j]*4 +: 4];
         if (on[j] && c >= 4'h1 && c <= 4'h3)
            r[c - 4'h1] = 1'b1;
      end
      for (int k = 0; k < 3; k++)
         if (pol_cfg[k*4 +: 4] == 4'h1)
            r[k] = !r[k];
      return r;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what,
            got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      logic rdy;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Answer is taken at the rising edge that shows pready high
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdy = pready;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check(32'(rdy), 32'h1, "ready");
   endtask

   // Write with junk in the upper half, then read back
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      apb(a, 1'b1, {16'($urandom), d}, rd, er);
      apb(a, 1'b0, 32'h0, rd, er);
      check(rd, {16'h0000, d}, "readback");
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Watchdog far beyond the few thousand cycles the tests need
   initial begin
      repeat (30000) @(posedge core_clk);
      miscompares++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      complete_run();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      contact_want = 6'h00;
      out_func_req = '0;
      out_func_valid = '0;
      miscompares = 0;
      n_tests = 0;
      void'($urandom(33830));
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      // Defaults, unmapped access, brake alone on pair one
      foreach (RST_VAL[i]) begin
         apb(8'(i * 4), 1'b0, 32'h0, rd, er);
         check(rd, {16'h0000, RST_VAL[i]}, "reset value");
      end
      apb(8'h28, 1'b0, 32'h0, rd, er);
      check(32'(er), 32'h1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
      @(posedge core_clk);
      out_func_req <= '1;
      out_func_valid <= '1;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check(32'(load_on), 32'h1, "default pairs");
      $display("test defaults done");
      // Input routing; the last two passes are shared-pin and fixed codes
      for (int t = 0; t < 42; t++) begin
         for (int r = 0; r < 4; r++)
            in_cfg[r] = 16'($urandom);
         in_cfg[2][7:4] = PROBE_OK[$urandom % 10];
         in_cfg[2][11:8] = PROBE_OK[$urandom % 10];
         if (t == 40)
            in_cfg = '{16'h3000, 16'h3B83, 16'h8723, 16'h888C};
         if (t == 41)
            in_cfg = '{16'h7888, 16'h7089, 16'h8477, 16'h8880};
         for (int r = 0; r < 4; r++)
            put(8'(r * 4), in_cfg[r]);
         @(posedge core_clk);
         contact_want <= 6'($urandom);
         repeat (6) @(posedge core_clk);
         @(negedge core_clk);
         check(32'(in_func_active), 32'(exp_in(contact_want)),
            "inputs");
         // Status word mirrors pins, input functions and default pairs
         apb(IOSM_OFS_STATUS, 1'b0, 32'h0, rd, er);
         check(rd, {15'h0000, 3'b001, exp_in(contact_want), contact_want},
            "status");
      end
      $display("test inputs done");
      // Output routing, merging, polarity and unevaluated functions
      for (int t = 0; t < 40; t++) begin
         for (int r = 0; r < 4; r++)
            out_cfg[r] = (t % 5 == 0) ? 16'($urandom) :
               16'($urandom) & 16'h3333;
         pol_cfg = {4'h0, 4'($urandom % 3), 4'($urandom % 3),
            4'($urandom % 3)};
         // Corners: one function alone on pair three, then all disabled
         if (t == 38) begin
            out_cfg = '{16'h0003, 16'h0000, 16'h0000, 16'h0000};
            pol_cfg = 16'h0000;
         end
         if (t == 39) begin
            out_cfg = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
            pol_cfg = 16'h0001;
         end
         for (int r = 0; r < 4; r++)
            put(8'(16 + r * 4), out_cfg[r]);
         put(IOSM_OFS_POL, pol_cfg);
         repeat (3) begin
            @(posedge core_clk);
            out_func_req <= iosm_out_func_s'(10'($urandom));
            out_func_valid <= iosm_out_func_s'(10'($urandom));
            repeat (2) @(posedge core_clk);
            @(negedge core_clk);
            check(32'(load_on), 32'(exp_out(out_func_req & out_func_valid)),
               "pairs");
         end
      end
      $display("test outputs done");
      complete_run();
   end
endmodule // tb_top
